// ---- verilog/rdo_regs.sv ----
// axi4-lite register slice for radio debug pins and frame marker
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
// Function
// - Each debug pin has a 6-bit selector in bits 5:0 choosing the internal signal, reset to zero.
// - Bit 6 of each pin config inverts the pin, 1 giving active low, reset to zero.
// - Bit 7 of the pin b config selects drive strength, 0 minimum and 1 maximum, reset to zero.
// - The high frame marker holds the upper sync word byte, read/write, reset 0xd3.
// - The low frame marker holds the lower sync word byte, read/write, reset 0x91.
// - The measured frequency offset is readable through a read-only status register.
module rdo_regs (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [17:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [17:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [63:0] internal_signals,
    input wire logic [7:0] frequency_offset_estimate,
    output logic debug_pin_a,
    output logic debug_pin_b,
    output logic debug_pin_c,
    output logic output_drive_strength,
    output logic [15:0] sync_word
);
    logic [17:0] awaddr_q;
    logic aw_have_q;
    logic [31:0] wdata_q;
    logic w_have_q;
    logic wstrb0_q;
    logic [7:0] marker_high_q;
    logic [7:0] marker_low_q;
    logic [7:0] pin_a_q;
    logic [7:0] pin_b_q;
    logic [7:0] pin_c_q;
    logic [7:0] freq_est_q;
    logic do_write;
    logic wr_hit;
    logic [7:0] rd_val;
    logic rd_hit;

    // channels accepted independently, one write in flight
    assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
    assign s_axi_wready = !w_have_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;

    // hold write address and data until both have arrived
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            awaddr_q <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
        end else if (do_write) begin
            aw_have_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_have_q <= 1'b0;
            wdata_q <= '0;
            wstrb0_q <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb0_q <= s_axi_wstrb[0];
        end else if (do_write) begin
            w_have_q <= 1'b0;
        end
    end

    // address decode for writes; status register is not writable
    always_comb begin
        unique case (awaddr_q)
            rdo_pkg::rdo_byte_addr(rdo_pkg::IDX_FRAME_MARKER_HIGH),
            rdo_pkg::rdo_byte_addr(rdo_pkg::IDX_FRAME_MARKER_LOW),
            rdo_pkg::rdo_byte_addr(rdo_pkg::IDX_DEBUG_PIN_C_CONFIG),
            rdo_pkg::rdo_byte_addr(rdo_pkg::IDX_DEBUG_PIN_B_CONFIG),
            rdo_pkg::rdo_byte_addr(rdo_pkg::IDX_DEBUG_PIN_A_CONFIG): wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // write response raised once both halves are in, dropped on bready
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // slverr on unmapped or read-only addresses, held with bvalid
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bresp <= rdo_pkg::RESP_OKAY;
        end else if (do_write) begin
            s_axi_bresp <= wr_hit ? rdo_pkg::RESP_OKAY : rdo_pkg::RESP_SLVERR;
        end
    end

    // register storage; only byte lane 0 carries data
    // upper lanes ignored: each register is one byte, so no merge logic needed
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            marker_high_q <= rdo_pkg::RST_FRAME_MARKER_HIGH;
            marker_low_q <= rdo_pkg::RST_FRAME_MARKER_LOW;
            pin_a_q <= rdo_pkg::RST_PIN_CONFIG;
            pin_b_q <= rdo_pkg::RST_PIN_CONFIG;
            pin_c_q <= rdo_pkg::RST_PIN_CONFIG;
        end else if (do_write && wstrb0_q) begin
            unique case (awaddr_q)
                rdo_pkg::rdo_byte_addr(rdo_pkg::IDX_FRAME_MARKER_HIGH): begin
                    marker_high_q <= wdata_q[7:0];
                end
                rdo_pkg::rdo_byte_addr(rdo_pkg::IDX_FRAME_MARKER_LOW): begin
                    marker_low_q <= wdata_q[7:0];
                end
                rdo_pkg::rdo_byte_addr(rdo_pkg::IDX_DEBUG_PIN_C_CONFIG): begin
                    pin_c_q <= wdata_q[7:0] & rdo_pkg::MASK_PIN_A_C;
                end
                rdo_pkg::rdo_byte_addr(rdo_pkg::IDX_DEBUG_PIN_B_CONFIG): begin
                    pin_b_q <= wdata_q[7:0] & rdo_pkg::MASK_PIN_B;
                end
                rdo_pkg::rdo_byte_addr(rdo_pkg::IDX_DEBUG_PIN_A_CONFIG): begin
                    pin_a_q <= wdata_q[7:0] & rdo_pkg::MASK_PIN_A_C;
                end
                default: begin
                end
            endcase
        end
    end

    // estimate sampled each cycle so a read sees a stable byte
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            freq_est_q <= rdo_pkg::RST_FREQ_EST;
        end else begin
            freq_est_q <= frequency_offset_estimate;
        end
    end

    // read decode
    always_comb begin
        rd_val = 8'h00;
        rd_hit = 1'b1;
        unique case (s_axi_araddr)
            rdo_pkg::rdo_byte_addr(rdo_pkg::IDX_FRAME_MARKER_HIGH): rd_val = marker_high_q;
            rdo_pkg::rdo_byte_addr(rdo_pkg::IDX_FRAME_MARKER_LOW): rd_val = marker_low_q;
            rdo_pkg::rdo_byte_addr(rdo_pkg::IDX_DEBUG_PIN_C_CONFIG): rd_val = pin_c_q;
            rdo_pkg::rdo_byte_addr(rdo_pkg::IDX_DEBUG_PIN_B_CONFIG): rd_val = pin_b_q;
            rdo_pkg::rdo_byte_addr(rdo_pkg::IDX_DEBUG_PIN_A_CONFIG): rd_val = pin_a_q;
            rdo_pkg::rdo_byte_addr(rdo_pkg::IDX_FREQ_OFFSET_EST): rd_val = freq_est_q;
            default: rd_hit = 1'b0;
        endcase
    end

    // read answered one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // data and code captured with the address, so they stand until rready
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rdata <= '0;
            s_axi_rresp <= rdo_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rdata <= {24'h000000, rd_val};
            s_axi_rresp <= rd_hit ? rdo_pkg::RESP_OKAY : rdo_pkg::RESP_SLVERR;
        end
    end

    // outputs to the radio and pad ring
    assign output_drive_strength = pin_b_q[rdo_pkg::DRIVE_BIT];
    assign sync_word = {marker_high_q, marker_low_q};

    // one mux per pin; selector and polarity from the config byte
    rdo_pin_mux u_pin_a (
        .aclk(aclk),
        .aresetn(aresetn),
        .internal_signals(internal_signals),
        .cfg(rdo_pkg::rdo_pin_cfg_t'(pin_a_q[rdo_pkg::POL_BIT:rdo_pkg::SEL_LSB])),
        .pin_q(debug_pin_a)
    );
    rdo_pin_mux u_pin_b (
        .aclk(aclk),
        .aresetn(aresetn),
        .internal_signals(internal_signals),
        .cfg(rdo_pkg::rdo_pin_cfg_t'(pin_b_q[rdo_pkg::POL_BIT:rdo_pkg::SEL_LSB])),
        .pin_q(debug_pin_b)
    );
    rdo_pin_mux u_pin_c (
        .aclk(aclk),
        .aresetn(aresetn),
        .internal_signals(internal_signals),
        .cfg(rdo_pkg::rdo_pin_cfg_t'(pin_c_q[rdo_pkg::POL_BIT:rdo_pkg::SEL_LSB])),
        .pin_q(debug_pin_c)
    );
endmodule

// ---- verilog/rdo_pkg.sv ----
// package for the radio debug output and frame marker register slice
package rdo_pkg;
    // printed offsets, kept as register indices (not all multiples of four)
    localparam logic [15:0] IDX_FRAME_MARKER_HIGH = 16'hdf00;
    localparam logic [15:0] IDX_FRAME_MARKER_LOW = 16'hdf01;
    localparam logic [15:0] IDX_DEBUG_PIN_C_CONFIG = 16'hdf2f;
    localparam logic [15:0] IDX_DEBUG_PIN_B_CONFIG = 16'hdf30;
    localparam logic [15:0] IDX_DEBUG_PIN_A_CONFIG = 16'hdf31;
    localparam logic [15:0] IDX_FREQ_OFFSET_EST = 16'hdf32;
    localparam logic [17:0] BUS_ADDR_BASE = 18'h00000;
    // field positions
    localparam int SEL_LSB = 0;
    localparam int SEL_W = 6;
    localparam int POL_BIT = 6;
    localparam int DRIVE_BIT = 7;
    // values after reset
    localparam logic [7:0] RST_FRAME_MARKER_HIGH = 8'hd3;
    localparam logic [7:0] RST_FRAME_MARKER_LOW = 8'h91;
    localparam logic [7:0] RST_PIN_CONFIG = 8'h00;
    localparam logic [7:0] RST_FREQ_EST = 8'h00;
    localparam logic RST_PIN_LEVEL = 1'h0;
    // writable bit masks per config register
    localparam logic [7:0] MASK_PIN_A_C = 8'h7f;
    localparam logic [7:0] MASK_PIN_B = 8'hff;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // one debug pin's configuration
    typedef struct packed {
        logic polarity;
        logic [5:0] signal_select;
    } rdo_pin_cfg_t;

    // word address helper: byte address is four times the index
    function automatic logic [17:0] rdo_byte_addr(input logic [15:0] idx);
        rdo_byte_addr = BUS_ADDR_BASE + {idx, 2'h0};
    endfunction
endpackage

// ---- verilog/rdo_pin_mux.sv ----
// one debug pin: signal select and polarity
`timescale 1ns/100ps
module rdo_pin_mux (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [63:0] internal_signals,
    input wire rdo_pkg::rdo_pin_cfg_t cfg,
    output logic pin_q
);
    // registered so the pin carries no decode glitches
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_q <= rdo_pkg::RST_PIN_LEVEL;
        end else begin
            pin_q <= internal_signals[cfg.signal_select] ^ cfg.polarity;
        end
    end
endmodule

// ---- sim/rdo_regs_chk.sv ----
// assertion checker for the radio debug pin and frame marker registers
`timescale 1ns/100ps
module rdo_regs_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [17:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_bvalid,
    input wire logic [63:0] internal_signals,
    input wire logic [7:0] frequency_offset_estimate,
    input wire logic debug_pin_a,
    input wire logic debug_pin_b,
    input wire logic debug_pin_c,
    input wire logic output_drive_strength,
    input wire logic [15:0] sync_word
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // read request taken at this edge
    wire logic ar = s_axi_arvalid && s_axi_arready;
    AST_SYNC_RST:
        assert property ($rose(aresetn) |-> sync_word == 16'hd391 && !output_drive_strength) else $error("bad reset");
    AST_PIN_RST:
        assert property ($rose(aresetn) |=> {debug_pin_a, debug_pin_b, debug_pin_c} == {3{$past(internal_signals[0])}})
            else $error("pin after reset");
    AST_HOLD:
        assert property ($changed(sync_word) || $changed(output_drive_strength) |-> $rose(s_axi_bvalid))
            else $error("change without write");
    AST_RD_FREQ:
        assert property (ar && s_axi_araddr == 18'h37cc8 && $stable(frequency_offset_estimate)
            |=> s_axi_rdata == {24'h0, frequency_offset_estimate}) else $error("estimate read");
    AST_RD_HIGH:
        assert property (ar && s_axi_araddr == 18'h37c00
            |=> !$stable(sync_word) || s_axi_rdata == {24'h0, sync_word[15:8]}) else $error("high read");
    AST_RD_LOW:
        assert property (ar && s_axi_araddr == 18'h37c04
            |=> !$stable(sync_word) || s_axi_rdata == {24'h0, sync_word[7:0]}) else $error("low read");
    AST_RD_UNUSED:
        assert property (ar && (s_axi_araddr == 18'h37cbc || s_axi_araddr == 18'h37cc4) |=> !s_axi_rdata[7])
            else $error("unused bit set");
    AST_RD_DRIVE:
        assert property (ar && s_axi_araddr == 18'h37cc0
            |=> !$stable(output_drive_strength) || s_axi_rdata[7] == output_drive_strength) else $error("drive read");
    cover property (ar && s_axi_araddr == 18'h37cc8);
    cover property ($changed(sync_word));
    cover property ($rose(debug_pin_a));
endmodule

bind rdo_regs rdo_regs_chk i_chk (.*);

// ---- sim/rdo_regs_tb.sv ----
// self-checking bench for the radio debug pin and frame marker registers
`timescale 1ns/100ps
module rdo_regs_tb;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [17:0] s_axi_awaddr = 18'h0, s_axi_araddr = 18'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d, seed = 32'h61;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic [63:0] internal_signals = 64'h0;
    logic [7:0] frequency_offset_estimate = 8'h0, v;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, s;
    logic debug_pin_a, debug_pin_b, debug_pin_c, output_drive_strength;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [15:0] sync_word;
    int errors = 0, tests_run = 0, cyc = 0, i;
    // model: high, low, pin c, pin b, pin a
    logic [7:0] mdl [5] = '{8'hd3, 8'h91, 8'h00, 8'h00, 8'h00};
    logic [7:0] msk [5] = '{8'hff, 8'hff, 8'h7f, 8'hff, 8'h7f};
    logic [17:0] adr [5] = '{18'h37c00, 18'h37c04, 18'h37cbc, 18'h37cc0, 18'h37cc4};

    rdo_regs i_dut (.*);

    always #4 aclk = ~aclk;

    function automatic void step();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
    endfunction

    // expected pin level from the model
    function automatic logic pin(input int j);
        return internal_signals[mdl[j][5:0]] ^ mdl[j][6];
    endfunction

    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    // one edge passes first, so back-to-back calls never drive a signal twice in one step;
    // ready sampled at the falling edge, released after the next rising one
    task automatic wr(input logic [17:0] a, input logic [7:0] val, input logic st);
        logic aw, w, b;
        @(posedge aclk);
        {aw, w, b} = 3'h7;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, val};
        s_axi_wstrb <= {3'h0, st};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        while (b) begin
            @(negedge aclk);
            aw = aw && !s_axi_awready;
            w = w && !s_axi_wready;
            b = b && !s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
            {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {aw, w, b};
        end
    endtask

    task automatic rd(input logic [17:0] a);
        logic ar, b;
        @(posedge aclk);
        {ar, b} = 2'h3;
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        while (b) begin
            @(negedge aclk);
            ar = ar && !s_axi_arready;
            b = b && !s_axi_rvalid;
            {r, d} = {s_axi_rresp, s_axi_rdata};
            @(posedge aclk);
            {s_axi_arvalid, s_axi_rready} <= {ar, b};
        end
    endtask

    task automatic print_verdict();
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // watchdog against a hung handshake
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            print_verdict();
        end
    end

    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        for (i = 0; i < 5; i++) begin
            rd(adr[i]);
            chk({r, d}, {26'h0, mdl[i]});
        end
        // random writes, some with the byte strobe off, then read back
        for (int k = 0; k < 40; k++) begin
            i = k % 5;
            step();
            internal_signals <= {seed, ~seed};
            step();
            v = seed[7:0];
            s = (k % 4 != 3);
            wr(adr[i], v, s);
            chk({r, 32'h0}, 34'h0);
            if (s)
                mdl[i] = v & msk[i];
            rd(adr[i]);
            chk({r, d}, {26'h0, mdl[i]});
            @(negedge aclk);
            chk({31'h0, debug_pin_a, debug_pin_b, debug_pin_c}, {31'h0, pin(4), pin(3), pin(2)});
            chk({17'h0, output_drive_strength, sync_word}, {17'h0, mdl[3][7], mdl[0], mdl[1]});
            @(posedge aclk);
        end
        // mid-run reset, long enough that no register change leaks past it
        aresetn <= 1'h0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'h1;
        mdl = '{8'hd3, 8'h91, 8'h00, 8'h00, 8'h00};
        for (i = 0; i < 5; i++) begin
            rd(adr[i]);
            chk({r, d}, {26'h0, mdl[i]});
        end
        @(negedge aclk);
        chk({31'h0, debug_pin_a, debug_pin_b, debug_pin_c}, {31'h0, pin(4), pin(3), pin(2)});
        chk({17'h0, output_drive_strength, sync_word}, {17'h0, mdl[3][7], mdl[0], mdl[1]});
        @(posedge aclk);
        // estimate is read only, unmapped places refused
        step();
        frequency_offset_estimate <= seed[7:0];
        wr(18'h37cc8, 8'h5a, 1'h1);
        chk({r, 32'h0}, {2'h2, 32'h0});
        rd(18'h37cc8);
        chk({r, d}, {26'h0, seed[7:0]});
        rd(18'h00010);
        chk({r, d}, {2'h2, 32'h0});
        print_verdict();
    end
endmodule
